/* File: verilog/brtp_rx_port.sv */
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module brtp_rx_port
    import brtp_pkg::*;
#(
    parameter int QUAD = 1
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        rx_backplane_clock_i,
    output logic             rx_backplane_clock_o,
    output logic             rx_backplane_clock_oe,
    input  wire logic        rx_frame_pulse_i,
    output logic             rx_frame_pulse_o,
    output logic             rx_frame_pulse_oe,
    output logic             rx_pcm_stream,
    output logic             rx_signalling_stream,
    input  wire logic        common_8m_clock,
    input  wire logic        common_pulse_clock,
    input  wire logic        common_frame_pulse_n,
    output logic             hs_data_out,
    output logic             hs_data_oe,
    output logic             hs_cas_out,
    output logic             hs_cas_oe,
    output logic      [4:0]  slot_index,
    input  wire brtp_slot_s  slot
);
    localparam logic [9:0] TS_IDX = (QUAD == 3) ? IDX_TS_Q3 :
                                    (QUAD == 2) ? IDX_TS_Q2 : IDX_TS_Q1;

    typedef struct packed {
        brtp_cfg_s        cfg;
        brtp_fpc_s        fpc;
        logic [6:0]       timeslot_offset;
        logic [31:0]      dtrk;
        logic [31:0]      prdata;
        logic             pslverr;
        logic [NCO_W-1:0] nco;
        logic             lvl;
        logic             clk_out;
        logic             prev;
        logic             fpc_prev;
        logic             fp_samp;
        logic             half;
        logic [9:0]       pos;
        logic [5:0]       dly;
        logic             dly_act;
        logic             pend;
        logic [4:0]       fcnt;
        logic             alt;
        logic             armed;
        logic             fp_q;
        logic [4:0]       ch;
        logic             pcm_q;
        logic             sig_q;
        logic             par_pcm;
        logic             par_sig;
        logic             hs_oe;
    } brtp_state_s;

    brtp_state_s      s;
    brtp_state_s      n;
    logic [4:0]       sy;
    logic             hs_act;
    logic             t1_193;
    logic             t1_gap;
    logic             unf_ok;
    logic             src;
    logic             edge_ev;
    logic             d_edge;
    logic             f_edge;
    logic             fp_ev;
    logic             hs_ev;
    logic             force_up;
    logic             upd;
    logic             restart;
    logic             wrap;
    logic             carry;
    logic             fbit_pos;
    logic             filler;
    logic             our;
    logic             pbit;
    logic             sbit;
    logic             gap;
    logic             mf_mode;
    logic             acc_en;
    logic [NCO_W-1:0] inc;
    logic [10:0]      len;
    logic [10:0]      off_m;
    logic [10:0]      dsum;
    logic [9:0]       dpos;
    logic [9:0]       dm1;
    logic [9:0]       pos_n;
    logic [4:0]       ch_n;
    logic [2:0]       bitn;
    logic [4:0]       mf_len;
    logic [4:0]       fcnt_n;

    ////////////////////////////////////////////////////////////////////////////
    // every pin from the far side, clocks included, crosses two flops
    brtp_sync #(.W(5)) u_sync (
        .clk (clk),
        .rstn(rstn),
        .d   ({rx_backplane_clock_i, rx_frame_pulse_i, common_8m_clock,
               common_pulse_clock, common_frame_pulse_n}),
        .q   (sy)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        n = s;
        hs_act = s.fpc.hs_mode_enable && s.cfg.clock_direction
                 && s.cfg.frame_pulse_direction && !s.cfg.data_edge_sel
                 && s.cfg.frame_edge_sel && s.cfg.clock_rate_double
                 && s.cfg.rate == RATE_HS;
        t1_193 = !s.cfg.line_standard_sel && s.cfg.rate == RATE_T1 && !hs_act;
        t1_gap = !s.cfg.line_standard_sel && !t1_193 && !hs_act;
        len = hs_act ? BITS_HS : (t1_193 ? BITS_T1 : BITS_E1);
        unf_ok = s.fpc.unframed_sel && s.fpc.elastic_store_bypass
                 && !s.cfg.clock_direction && !s.cfg.frame_pulse_direction;

        // edge source: 8M clock, slave clock pin or own divider
        src = hs_act ? sy[2] : (s.cfg.clock_direction ? sy[4] : s.lvl);
        edge_ev = src != s.prev;
        n.prev = src;
        inc = t1_193 ? INC_T1 : INC_E1;
        if (s.cfg.clock_rate_double) begin
            inc = inc << 1;
        end
        {carry, n.nco} = {1'b0, s.nco} + {1'b0, inc};
        if (carry && !s.cfg.clock_direction) begin
            n.lvl = !s.lvl;
        end
        d_edge = edge_ev && (src == s.cfg.data_edge_sel);
        f_edge = edge_ev && (src == s.cfg.frame_edge_sel);

        // frame pulse inputs
        fp_ev = 1'b0;
        hs_ev = 1'b0;
        n.fpc_prev = sy[1];
        if (hs_act) begin
            hs_ev = s.fpc_prev && !sy[1] && !sy[0];
        end else if (s.cfg.frame_pulse_direction && f_edge) begin
            n.fp_samp = sy[3];
            fp_ev = sy[3] && !s.fp_samp;
        end

        // bit update timing
        force_up = hs_ev || (s.dly_act && edge_ev && s.dly == 6'h01);
        upd = 1'b0;
        if (d_edge) begin
            n.half = !s.half;
            upd = !s.cfg.clock_rate_double || s.half;
        end
        if (edge_ev && s.dly_act) begin
            n.dly = s.dly - 6'h01;
            n.dly_act = s.dly != 6'h01;
        end
        restart = force_up || (upd && s.pend);
        if (force_up) begin
            upd = 1'b1;
            n.half = 1'b0;
        end
        if (restart) begin
            n.pend = 1'b0;
        end
        if (fp_ev) begin
            if (s.cfg.bit_offset_enable) begin
                n.dly = CET_TAB[s.cfg.bit_offset];
                n.dly_act = 1'b1;
            end else begin
                n.pend = 1'b1;
            end
        end

        // position and channel of the next bit
        wrap = restart || ({1'b0, s.pos} + 11'h001 == len);
        pos_n = wrap ? 10'h000 : s.pos + 10'h001;
        // an offset at or past the frame length is ignored
        off_m = ({1'b0, s.timeslot_offset, 3'h0} < len) ? {1'b0, s.timeslot_offset, 3'h0} : 11'h000;
        dsum = {1'b0, pos_n} + len - off_m;
        dpos = (dsum >= len) ? 10'(dsum - len) : 10'(dsum);
        dm1 = dpos - 10'h001;
        fbit_pos = 1'b0;
        filler = 1'b0;
        our = 1'b1;
        bitn = dpos[2:0];
        ch_n = dpos[7:3];
        if (t1_193) begin
            fbit_pos = dpos == 10'h000;
            ch_n = dm1[7:3] + 5'h01;
            bitn = dm1[2:0];
        end else if (hs_act) begin
            ch_n = dpos[9:5];
            our = dpos[4:3] == 2'h0;
        end else if (t1_gap) begin
            fbit_pos = dpos == 10'h000;
            filler = !fbit_pos && (dpos[7:3] == 5'h00 || dpos[7:3] > LAST_T1_CH);
        end
        pbit = slot.pcm[~bitn];
        sbit = bitn[2] && slot.sig[~bitn[1:0]];
        if (fbit_pos) begin
            pbit = slot.fbit;
            sbit = 1'b0;
        end else if (filler) begin
            pbit = 1'b1;
            sbit = 1'b1;
        end
        acc_en = !hs_act || our;

        // frame and multiframe counting
        mf_mode = s.fpc.superframe_pulse_sel
                  || (s.cfg.line_standard_sel && !s.fpc.overhead_mode_sel
                      && s.fpc.crc_multiframe_pulse_sel);
        mf_len = s.cfg.line_standard_sel ? MF_E1 : (s.fpc.superframe_len24 ? ESF_T1 : SF_T1);
        fcnt_n = (!mf_mode || restart || s.fcnt + 5'h01 >= mf_len) ? 5'h00
                 : s.fcnt + 5'h01;

        if (upd) begin
            n.pos = pos_n;
            n.ch = ch_n;
            n.hs_oe = hs_act && our;
            if (dpos == 10'h000 && s.cfg.rx_parity_enable && !unf_ok) begin
                n.pcm_q = s.par_pcm;
                n.sig_q = s.par_sig;
                n.par_pcm = 1'b0;
                n.par_sig = 1'b0;
            end else begin
                n.pcm_q = pbit;
                n.sig_q = sbit;
                n.par_pcm = s.par_pcm ^ (pbit && acc_en);
                n.par_sig = s.par_sig ^ (sbit && acc_en);
            end
            if (wrap) begin
                n.fcnt = fcnt_n;
                if (fcnt_n == 5'h00) begin
                    if (s.fpc.alternate_pulse_sel) begin
                        n.alt = !s.alt;
                    end
                    n.armed = !s.cfg.frame_pulse_direction && !unf_ok
                              && (!s.fpc.alternate_pulse_sel || !s.alt);
                end
            end
        end

        // pulse goes out on the frame edge and drops on the next one
        if (f_edge) begin
            n.fp_q = n.armed;
            n.armed = 1'b0;
        end

        // gapped clock parks at the data edge level
        gap = s.cfg.nx64_sel && !s.cfg.clock_direction && s.dtrk[s.ch];
        n.clk_out = gap ? s.cfg.data_edge_sel : n.lvl;

        ////////////////////////////////////////////////////////////////////////
        // apb: read data and error are set up in the setup phase
        if (psel && !penable) begin
            n.pslverr = 1'b0;
            n.prdata = 32'h0000_0000;
            case (paddr[11:2])
                IDX_CFG:  n.prdata = 32'(s.cfg);
                IDX_FPC:  n.prdata = 32'(s.fpc);
                TS_IDX:   n.prdata = 32'(s.timeslot_offset);
                IDX_DTRK: n.prdata = s.dtrk;
                IDX_STAT: n.prdata = 32'({hs_act, unf_ok, s.fcnt, s.pos});
                default:  n.pslverr = 1'b1;
            endcase
        end
        if (psel && penable && pwrite) begin
            case (paddr[11:2])
                IDX_CFG:  n.cfg = pwdata[CFG_W-1:0];
                IDX_FPC:  n.fpc = pwdata[FPC_W-1:0];
                TS_IDX:   n.timeslot_offset = pwdata[6:0];
                IDX_DTRK: n.dtrk = pwdata;
                default:  ;
            endcase
        end
    end

    // all controls reset to zero: master, falling edges, t1 1.544
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign prdata = s.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && s.pslverr;
    assign slot_index = ch_n;
    assign rx_backplane_clock_o = s.clk_out;
    assign rx_backplane_clock_oe = !s.cfg.clock_direction;
    assign rx_frame_pulse_o = s.fp_q;
    assign rx_frame_pulse_oe = !s.cfg.frame_pulse_direction;
    assign rx_pcm_stream = s.pcm_q;
    assign rx_signalling_stream = s.sig_q;
    assign hs_data_out = s.pcm_q;
    assign hs_data_oe = s.hs_oe;
    assign hs_cas_out = s.sig_q;
    assign hs_cas_oe = s.hs_oe;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_fp_width;
        !s.cfg.frame_pulse_direction && s.fp_q && f_edge |=> !s.fp_q;
    endproperty
    a_fp_width: assert property (p_fp_width) else $error("frame pulse too long");

    property p_mf_pulse;
        $rose(s.fp_q) && mf_mode |-> s.fcnt == 5'h00;
    endproperty
    a_mf_pulse: assert property (p_mf_pulse) else $error("pulse off boundary");

    property p_alt;
        $rose(s.fp_q) && s.fpc.alternate_pulse_sel |-> s.alt;
    endproperty
    a_alt: assert property (p_alt) else $error("alternate pulse wrong");

    property p_edge;
        $changed(s.pos) |-> $past(d_edge || force_up);
    endproperty
    a_edge: assert property (p_edge) else $error("data moved off edge");

    property p_fe;
        $rose(s.fp_q) |-> $past(f_edge);
    endproperty
    a_fe: assert property (p_fe) else $error("pulse moved off edge");

    property p_par;
        upd && dpos == 10'h000 && s.cfg.rx_parity_enable && !unf_ok
            |=> s.pcm_q == $past(s.par_pcm) && !s.par_pcm;
    endproperty
    a_par: assert property (p_par) else $error("parity bit wrong");

    property p_gap;
        gap |=> s.clk_out == $past(s.cfg.data_edge_sel);
    endproperty
    a_gap: assert property (p_gap) else $error("clock not gapped");

    property p_chi;
        s.dly_act && edge_ev && s.dly == 6'h01 |=> s.pos == 10'h000 && !s.dly_act;
    endproperty
    a_chi: assert property (p_chi) else $error("chi offset wrong");

    property p_hs;
        hs_ev |=> s.pos == 10'h000 && !s.half;
    endproperty
    a_hs: assert property (p_hs) else $error("frame start missed");

    c_fp: cover property ($rose(s.fp_q));
    c_hs: cover property (hs_ev);
    c_chi: cover property (force_up && !hs_ev);
    c_gap: cover property (gap && upd);
endmodule
`default_nettype wire

/* File: verilog/brtp_pkg.sv */
`default_nettype none
package brtp_pkg;

    ////////////////////////////////////////////////////////////////////////////
    localparam int CLK_HZ = 25_000_000;
    localparam int T1_BPS = 1_544_000;
    localparam int E1_BPS = 2_048_000;
    localparam int NCO_W  = 24;
    // edge rate is twice the clock rate, so the nco carries once per edge
    localparam logic [NCO_W-1:0] INC_T1 = NCO_W'((64'(2 * T1_BPS) << NCO_W) / 64'(CLK_HZ));
    localparam logic [NCO_W-1:0] INC_E1 = NCO_W'((64'(2 * E1_BPS) << NCO_W) / 64'(CLK_HZ));

    ////////////////////////////////////////////////////////////////////////////
    localparam logic [10:0] BITS_T1 = 11'h0c1;
    localparam logic [10:0] BITS_E1 = 11'h100;
    localparam logic [10:0] BITS_HS = 11'h400;
    localparam logic [4:0]  SF_T1   = 5'h0c;
    localparam logic [4:0]  ESF_T1  = 5'h18;
    localparam logic [4:0]  MF_E1   = 5'h10;
    localparam logic [4:0]  LAST_T1_CH = 5'h18;
    localparam logic [1:0]  RATE_T1 = 2'h0;
    localparam logic [1:0]  RATE_HS = 2'h3;
    // clock edges from frame pulse to first data update, by bit offset code
    localparam logic [7:0][5:0] CET_TAB = {6'h20, 6'h1c, 6'h18, 6'h14,
                                           6'h10, 6'h0c, 6'h08, 6'h03};

    ////////////////////////////////////////////////////////////////////////////
    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_CFG   = 10'h030;
    localparam logic [9:0] IDX_FPC   = 10'h031;
    localparam logic [9:0] IDX_TS_Q1 = 10'h033;
    localparam logic [9:0] IDX_TS_Q2 = 10'h133;
    localparam logic [9:0] IDX_TS_Q3 = 10'h233;
    localparam logic [9:0] IDX_DTRK  = 10'h034;
    localparam logic [9:0] IDX_STAT  = 10'h035;
    localparam int CFG_W = 14;
    localparam int FPC_W = 8;

    typedef struct packed {
        logic       nx64_sel;
        logic       line_standard_sel;
        logic       rx_parity_enable;
        logic [2:0] bit_offset;
        logic       bit_offset_enable;
        logic [1:0] rate;
        logic       clock_rate_double;
        logic       frame_edge_sel;
        logic       data_edge_sel;
        logic       frame_pulse_direction;
        logic       clock_direction;
    } brtp_cfg_s;

    typedef struct packed {
        logic elastic_store_bypass;
        logic unframed_sel;
        logic hs_mode_enable;
        logic superframe_len24;
        logic alternate_pulse_sel;
        logic overhead_mode_sel;
        logic crc_multiframe_pulse_sel;
        logic superframe_pulse_sel;
    } brtp_fpc_s;

    typedef struct packed {
        logic [7:0] pcm;
        logic [3:0] sig;
        logic       fbit;
    } brtp_slot_s;

endpackage
`default_nettype wire

/* File: verilog/brtp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module brtp_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } brtp_sy_s;

    brtp_sy_s s;
    brtp_sy_s n;

    // first stage feeds only the second
    always_comb begin
        n = s;
        n.s1 = d;
        n.s2 = s.s1;
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s <= '0;
        end else begin
            s <= n;
        end
    end

    assign q = s.s2;
endmodule
`default_nettype wire

/* File: verif/brtp_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
module brtp_far_end #(
    parameter int HALF = 160
) (
    input  wire logic en,
    output logic      lclk,
    output logic      lfp
);
    ////////////////////////////////////////////////////////////////////////////
    // odd start offset keeps the link clock out of phase with clk
    initial begin
        lclk = 1'b0;
        lfp  = 1'b0;
        wait (en === 1'b1);
        #37;
        // single pulse only: later frames must stay aligned without it
        lfp = 1'b1;
        repeat (2) #HALF lclk = ~lclk;
        lfp = 1'b0;
        forever #HALF lclk = ~lclk;
    end
endmodule
`default_nettype wire

/* File: verif/brtp_rx_port_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module brtp_rx_port_tb
    import brtp_pkg::*;
;
    localparam logic [11:0] CFG_A  = {IDX_CFG, 2'b00};
    localparam logic [11:0] FPC_A  = {IDX_FPC, 2'b00};
    localparam logic [11:0] TS_A   = {IDX_TS_Q1, 2'b00};
    localparam logic [11:0] DTRK_A = {IDX_DTRK, 2'b00};
    localparam logic [11:0] STAT_A = {IDX_STAT, 2'b00};
    logic        clk, rstn, psel, penable, pwrite, lk_en, odd_sel, lclk, lfp;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic        pready, pslverr, bck_o, bck_oe, fp_o, fp_oe, pcm, sig;
    logic [4:0]  sidx;
    brtp_slot_s  slot;
    logic        bck_p, lclk_p, fp_p, pcm_p, pcm_at_fp, sig_at_fp, ck_at_pcm, ck_at_fp;
    int          err_total, tests_run, bck_rises, l_rises, fp_cnt, pcm_cnt, last_w, run_w;

    brtp_rx_port #(.QUAD(1)) dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_backplane_clock_i(lclk), .rx_backplane_clock_o(bck_o),
        .rx_backplane_clock_oe(bck_oe), .rx_frame_pulse_i(lfp), .rx_frame_pulse_o(fp_o),
        .rx_frame_pulse_oe(fp_oe), .rx_pcm_stream(pcm), .rx_signalling_stream(sig),
        .common_8m_clock(1'b0), .common_pulse_clock(1'b0), .common_frame_pulse_n(1'b1),
        .hs_data_out(), .hs_data_oe(), .hs_cas_out(), .hs_cas_oe(), .slot_index(sidx),
        .slot(slot));
    brtp_far_end far (.en(lk_en), .lclk(lclk), .lfp(lfp));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // odd data: one bit in slot 5 only, so even parity gives a 1
    always @(posedge clk) begin
        slot <= '{pcm: (odd_sel && sidx == 5'h05) ? 8'h01 : 8'h00,
                  sig: (odd_sel && sidx == 5'h05) ? 4'h1 : 4'h0, fbit: !odd_sel};
    end
    // sampled at negedge where outputs have settled
    always @(negedge clk) begin
        if (bck_o === 1'b1 && bck_p === 1'b0) bck_rises++;
        if (lclk === 1'b1 && lclk_p === 1'b0) l_rises++;
        if (fp_o === 1'b1 && fp_p === 1'b0) begin
            fp_cnt++;
            pcm_at_fp = pcm;
            sig_at_fp = sig;
            ck_at_fp  = bck_o;
        end
        if (fp_o !== 1'b1 && fp_p === 1'b1) last_w = run_w;
        run_w = (fp_o === 1'b1) ? run_w + 1 : 0;
        if (pcm !== pcm_p) ck_at_pcm = bck_o;
        if (pcm === 1'b1 && pcm_p === 1'b0) pcm_cnt++;
        {bck_p, lclk_p, fp_p, pcm_p} = {bck_o, lclk, fp_o, pcm};
    end

    ////////////////////////////////////////////////////////////////////////////
    task report_and_stop;
        $display("errors %0d, checks %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        // no wait limit here: only the watchdog ends a hung access
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task cfg(input logic [31:0] c, input logic [31:0] f);
        logic [31:0] r;
        logic        e;
        apb(1'b1, CFG_A, c, r, e);
        apb(1'b1, FPC_A, f, r, e);
    endtask
    // link clock rises (pcm) or output clock rises (frame) between two successive pulses
    task gap(input logic use_pcm, output int n);
        int a, c, k;
        for (int j = 0; j < 2; j++) begin
            a = use_pcm ? l_rises : bck_rises;
            c = use_pcm ? pcm_cnt : fp_cnt;
            for (k = 0; k < 20000 && c == (use_pcm ? pcm_cnt : fp_cnt); k++) @(negedge clk);
        end
        n = (use_pcm ? l_rises : bck_rises) - a;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task t_regs;
        logic [31:0] r;
        logic        e;
        chk(32'(bck_oe), 32'h1, "clock oe");
        chk(32'(fp_oe), 32'h1, "pulse oe");
        apb(1'b0, CFG_A, 32'h0, r, e);
        chk(r, 32'h0, "cfg reset");
        apb(1'b1, CFG_A, 32'hFFFF_FFFF, r, e);
        apb(1'b0, CFG_A, 32'h0, r, e);
        chk(r, 32'h0000_3FFF, "cfg rw");
        apb(1'b1, TS_A, 32'hFFFF_FFFF, r, e);
        apb(1'b0, TS_A, 32'h0, r, e);
        chk(r, 32'h0000_007F, "offset rw");
        apb(1'b1, TS_A, 32'h0, r, e);
        apb(1'b0, 12'h0E0, 32'h0, r, e);
        chk({r[30:0], e}, 32'h0000_0001, "unmapped");
        apb(1'b1, STAT_A, 32'hFFFF_FFFF, r, e);
        chk(32'(e), 32'h0, "status write");
    endtask
    task t_master;
        int n;
        cfg(32'h0, 32'h0);
        gap(1'b0, n);
        chk(32'(n), 32'(BITS_T1), "t1 frame");
        chk(32'(last_w == 16 || last_w == 17), 32'h1, "pulse width");
        chk(32'(pcm_at_fp), 32'h1, "fbit at pulse");
        chk(32'(ck_at_pcm), 32'h0, "pcm falling");
        chk(32'(ck_at_fp), 32'h0, "pulse falling");
        cfg(32'h0, 32'h0000_0008);
        gap(1'b0, n);
        chk(32'(n), 32'(2 * BITS_T1), "alternate");
    endtask
    task t_parity_e1;
        int n;
        odd_sel <= 1'b1;
        cfg(32'h0000_0800, 32'h0);
        gap(1'b0, n);
        chk(32'(pcm_at_fp), 32'h1, "pcm parity");
        chk(32'(sig_at_fp), 32'h1, "sig parity");
        // odd data stays on: e1 has no framing bit, so pcm needs a 1 to toggle
        cfg(32'h0000_102C, 32'h0);
        gap(1'b0, n);
        chk(32'(n), 32'(BITS_E1), "e1 frame");
        chk(32'(ck_at_pcm), 32'h1, "pcm rising");
        chk(32'(ck_at_fp), 32'h1, "pulse rising");
    endtask
    task t_gap_unf;
        int n, c;
        logic [31:0] r;
        logic        e;
        cfg(32'h0000_2000, 32'h0);
        apb(1'b1, DTRK_A, ~32'h0000_0004, r, e);
        gap(1'b0, n);
        chk(32'(n), 32'h8, "nx64 clocks");
        apb(1'b1, DTRK_A, 32'h0, r, e);
        cfg(32'h0, 32'h0000_00C0);
        // let a pulse armed before the write drain out first
        repeat (40) @(negedge clk);
        c = fp_cnt;
        // longer than one t1 frame
        repeat (4000) @(negedge clk);
        chk(32'(fp_cnt - c), 32'h0, "unframed pulse");
    endtask
    task t_slave;
        int n;
        cfg(32'h0000_102F, 32'h0);
        @(posedge clk);
        lk_en <= 1'b1;
        @(negedge clk);
        chk(32'({bck_oe, fp_oe}), 32'h0, "slave oe");
        // skip the update before the restart lands on bit 0
        repeat (40) @(negedge clk);
        gap(1'b1, n);
        chk(32'(n), 32'(BITS_E1), "slave frame");
        gap(1'b1, n);
        chk(32'(n), 32'(BITS_E1), "aligned w/o pulse");
        cfg(32'h0000_103F, 32'h0);
        gap(1'b1, n);
        chk(32'(n), 32'(2 * BITS_E1), "double rate clock");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata, lk_en, odd_sel} = '0;
        {err_total, tests_run, bck_rises, l_rises, fp_cnt, pcm_cnt, last_w, run_w} = '0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        t_regs;
        t_master;
        t_parity_e1;
        t_gap_unf;
        t_slave;
        report_and_stop;
    end
    initial begin
        #4_000_000;
        err_total++;
        report_and_stop;
    end
endmodule
`default_nettype wire
